// ### logic/pich_defs.svh
// Offsets, fields, codes and timing counts of the interrupt host port
`ifndef PICH_DEFS_SVH
`define PICH_DEFS_SVH
// APB register byte offsets
`define PICH_OFF_CTRL      8'h00
`define PICH_OFF_WDATA     8'h04
`define PICH_OFF_RDATA     8'h08
`define PICH_OFF_STAT      8'h0C
`define PICH_OFF_IRQ_STAT  8'h10
`define PICH_OFF_IRQ_MASK  8'h14
`define PICH_OFF_VECTOR    8'h18
// Command field positions in the control word
`define PICH_CMD_GO        0
`define PICH_CMD_READ      1
`define PICH_CMD_ADDR      2
`define PICH_CMD_ACK       3
`define PICH_CMD_MODE86    4
// Status-bit positions
`define PICH_EV_DONE       0
`define PICH_EV_INT        1
// Device call code
`define PICH_CALL_CODE     8'hCD
// Pin timing in ns and cycles at 50 MHz
`define PICH_CLK_NS        20
`define PICH_STROBE_NS     190
`define PICH_GAP_NS        400
`define PICH_STROBE_CYC    (((`PICH_STROBE_NS)+(`PICH_CLK_NS)-1)/(`PICH_CLK_NS))
`define PICH_GAP_CYC       (((`PICH_GAP_NS)+(`PICH_CLK_NS)-1)/(`PICH_CLK_NS))
`endif

// ### logic/pich_pkg.sv
// Types of the interrupt host port
package pich_pkg;
    typedef enum logic [4:0] {
        PICH_IDLE  = 5'b00001,
        PICH_SETUP = 5'b00010,
        PICH_PULSE = 5'b00100,
        PICH_GAP   = 5'b01000,
        PICH_NEXT  = 5'b10000
    } pich_state_t;

    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic       ack_n;
        logic       port_select_bit;
        logic [7:0] dout;
        logic       doe;
    } pich_pins_t;

    typedef struct packed {
        pich_state_t state;
        pich_pins_t  pins;
        logic [4:0]  cnt;
        logic        is_read;
        logic        is_ack;
        logic        mode86;
        logic [1:0]  pulse_idx;
        logic        busy;
        logic [7:0]  rdata;
        logic [23:0] vector;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic [7:0]  wdata;
        logic        cmd_addr;
        logic        int_seen;
        logic [31:0] prdata;
    } pich_st_t;
endpackage

// ### logic/pich_host.sv
// Host controller that drives the interrupt controller pins from APB
`include "pich_defs.svh"

module pich_host
    import pich_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             cs_n,
    output logic             rd_n,
    output logic             wr_n,
    output logic             irq_acknowledge_n,
    output logic             port_select_bit,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe,
    input  wire logic        dev_int
);

    // ========================================
    // State
    pich_st_t st_reg;
    pich_st_t st_next;

    localparam logic [4:0] STROBE_CYC = 5'(`PICH_STROBE_CYC);
    localparam logic [4:0] GAP_CYC    = 5'(`PICH_GAP_CYC);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    logic apb_wr;
    logic apb_rd;
    logic pulse_end;
    logic last_pulse;
    assign apb_wr    = psel && penable && pwrite;
    assign apb_rd    = psel && penable && !pwrite;
    assign pulse_end = st_reg.cnt == 5'h00;
    assign last_pulse = st_reg.mode86 ? (st_reg.pulse_idx == 2'h1)
                                      : (st_reg.pulse_idx == 2'h2);

    // ========================================
    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.int_seen = dev_int;
        if (dev_int && !st_reg.int_seen) begin
            st_next.irq_stat[`PICH_EV_INT] = 1'b1;
        end
        case (st_reg.state)
            PICH_IDLE: begin
                st_next.pins = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                 ack_n: 1'b1, port_select_bit: 1'b0,
                                 dout: 8'h00, doe: 1'b0};
                if (st_reg.busy) begin
                    st_next.state = PICH_SETUP;
                    st_next.pins.port_select_bit = st_reg.cmd_addr;
                    st_next.pins.cs_n = st_reg.is_ack;
                    st_next.cnt = STROBE_CYC;
                    st_next.pulse_idx = 2'h0;
                end
            end
            PICH_SETUP: begin
                st_next.state = PICH_PULSE;
                if (st_reg.is_ack) begin
                    st_next.pins.ack_n = 1'b0;
                end else if (st_reg.is_read) begin
                    st_next.pins.rd_n = 1'b0;
                end else begin
                    st_next.pins.wr_n = 1'b0;
                    st_next.pins.dout = st_reg.wdata;
                    st_next.pins.doe = 1'b1;
                end
            end
            PICH_PULSE: begin
                st_next.cnt = st_reg.cnt - 5'h01;
                if (pulse_end) begin
                    st_next.pins.rd_n = 1'b1;
                    st_next.pins.wr_n = 1'b1;
                    st_next.pins.ack_n = 1'b1;
                    st_next.state = PICH_GAP;
                    st_next.cnt = GAP_CYC;
                    if (st_reg.is_read) begin
                        st_next.rdata = data_in;
                    end
                    if (st_reg.is_ack) begin
                        case (st_reg.pulse_idx)
                            2'h0: st_next.vector[7:0] = data_in;
                            2'h1: begin
                                if (st_reg.mode86) begin
                                    st_next.vector[7:0] = data_in;
                                end else begin
                                    st_next.vector[15:8] = data_in;
                                end
                            end
                            default: st_next.vector[23:16] = data_in;
                        endcase
                    end
                end
            end
            PICH_GAP: begin
                st_next.pins.doe = 1'b0;
                st_next.cnt = st_reg.cnt - 5'h01;
                if (pulse_end) begin
                    st_next.state = PICH_NEXT;
                end
            end
            PICH_NEXT: begin
                if (st_reg.is_ack && !last_pulse) begin
                    st_next.pulse_idx = st_reg.pulse_idx + 2'h1;
                    st_next.cnt = STROBE_CYC;
                    st_next.state = PICH_SETUP;
                end else begin
                    st_next.pins.cs_n = 1'b1;
                    st_next.busy = 1'b0;
                    st_next.irq_stat[`PICH_EV_DONE] = 1'b1;
                    st_next.state = PICH_IDLE;
                end
            end
            default: st_next.state = PICH_IDLE;
        endcase
        // APB writes; hardware set wins over a write-one clear
        if (apb_wr && hit(paddr, `PICH_OFF_CTRL) && !st_reg.busy
            && pwdata[`PICH_CMD_GO]) begin
            st_next.busy = 1'b1;
            st_next.is_read = pwdata[`PICH_CMD_READ];
            st_next.cmd_addr = pwdata[`PICH_CMD_ADDR];
            st_next.is_ack = pwdata[`PICH_CMD_ACK];
            st_next.mode86 = pwdata[`PICH_CMD_MODE86];
            if (pwdata[`PICH_CMD_ACK]) begin
                st_next.vector = 24'h000000;
            end
        end
        if (apb_wr && hit(paddr, `PICH_OFF_WDATA) && !st_reg.busy) begin
            st_next.wdata = pwdata[7:0];
        end
        if (apb_wr && hit(paddr, `PICH_OFF_IRQ_MASK)) begin
            st_next.irq_mask = pwdata[1:0];
        end
        if (apb_wr && hit(paddr, `PICH_OFF_IRQ_STAT)) begin
            st_next.irq_stat = st_reg.irq_stat & ~pwdata[1:0];
            if (st_next.state == PICH_IDLE && st_reg.state == PICH_NEXT) begin
                st_next.irq_stat[`PICH_EV_DONE] = 1'b1;
            end
            if (dev_int && !st_reg.int_seen) begin
                st_next.irq_stat[`PICH_EV_INT] = 1'b1;
            end
        end
        case (paddr)
            `PICH_OFF_CTRL:     st_next.prdata = {27'h0, st_reg.mode86,
                                    st_reg.is_ack, st_reg.cmd_addr,
                                    st_reg.is_read, st_reg.busy};
            `PICH_OFF_WDATA:    st_next.prdata = {24'h0, st_reg.wdata};
            `PICH_OFF_RDATA:    st_next.prdata = {24'h0, st_reg.rdata};
            `PICH_OFF_STAT:     st_next.prdata = {29'h0, dev_int,
                                    st_reg.pulse_idx == 2'h0, st_reg.busy};
            `PICH_OFF_IRQ_STAT: st_next.prdata = {30'h0, st_reg.irq_stat};
            `PICH_OFF_IRQ_MASK: st_next.prdata = {30'h0, st_reg.irq_mask};
            `PICH_OFF_VECTOR:   st_next.prdata = {8'h00, st_reg.vector};
            default:            st_next.prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_reg <= '{state: PICH_IDLE,
                        pins: '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                ack_n: 1'b1, port_select_bit: 1'b0,
                                dout: 8'h00, doe: 1'b0},
                        default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ========================================
    // Outputs
    // No cascade or slave-program pin here
    assign prdata            = st_reg.prdata;
    assign pready            = 1'b1;
    assign pslverr           = 1'b0;
    assign irq               = |(st_reg.irq_stat & st_reg.irq_mask);
    assign cs_n              = st_reg.pins.cs_n;
    assign rd_n              = st_reg.pins.rd_n;
    assign wr_n              = st_reg.pins.wr_n;
    assign irq_acknowledge_n = st_reg.pins.ack_n;
    assign port_select_bit   = st_reg.pins.port_select_bit;
    assign data_out          = st_reg.pins.dout;
    assign data_oe           = st_reg.pins.doe;

    // ========================================
    // Checks on the device pins
    AST_NO_RDWR: assert property (
        @(posedge clock) disable iff (srst)
        !(!rd_n && !wr_n))
        else $error("read and write together");

    AST_IDLE_CS: assert property (
        @(posedge clock) disable iff (srst)
        (st_reg.state == PICH_IDLE && !st_reg.busy) |-> cs_n)
        else $error("chip select low while idle");

    AST_STROBE_CS: assert property (
        @(posedge clock) disable iff (srst)
        (!rd_n || !wr_n) |-> !cs_n)
        else $error("read or write strobe without chip select");

    AST_OE_CS: assert property (
        @(posedge clock) disable iff (srst)
        data_oe |-> (!cs_n && irq_acknowledge_n))
        else $error("bus driven outside a write");

    AST_ACK_CS: assert property (
        @(posedge clock) disable iff (srst)
        !irq_acknowledge_n |-> cs_n)
        else $error("chip select low during acknowledge");

    AST_WIDTH: assert property (
        @(posedge clock) disable iff (srst)
        $fell(rd_n) |-> !rd_n [*8])
        else $error("read strobe too short");

    AST_WR_WIDTH: assert property (
        @(posedge clock) disable iff (srst)
        $fell(wr_n) |-> !wr_n [*8])
        else $error("write strobe too short");

    AST_ACK_WIDTH: assert property (
        @(posedge clock) disable iff (srst)
        $fell(irq_acknowledge_n) |-> !irq_acknowledge_n [*8])
        else $error("acknowledge pulse too short");

    AST_ACK_GAP: assert property (
        @(posedge clock) disable iff (srst)
        $rose(irq_acknowledge_n) |-> irq_acknowledge_n [*8])
        else $error("acknowledge pulses too close");

    AST_ADDR_HOLD: assert property (
        @(posedge clock) disable iff (srst)
        (!rd_n || !wr_n) |-> $stable(port_select_bit))
        else $error("address bit moved during a strobe");

    AST_WR_DATA: assert property (
        @(posedge clock) disable iff (srst)
        !wr_n |-> data_oe)
        else $error("write without data drive");

    AST_ACK_NO_DRV: assert property (
        @(posedge clock) disable iff (srst)
        !irq_acknowledge_n |-> !data_oe)
        else $error("bus driven in acknowledge");

    // ========================================
    // Checks on status and sequencing
    AST_INT_EV: assert property (
        @(posedge clock) disable iff (srst)
        $rose(dev_int) |-> ##[1:2] st_reg.irq_stat[`PICH_EV_INT])
        else $error("interrupt event lost");

    AST_DONE_EV: assert property (
        @(posedge clock) disable iff (srst)
        $fell(st_reg.busy) |-> st_reg.irq_stat[`PICH_EV_DONE])
        else $error("done event lost");

    AST_CALL_LEN: assert property (
        @(posedge clock) disable iff (srst)
        (st_reg.is_ack && !st_reg.mode86 && st_reg.state != PICH_IDLE)
        |-> st_reg.pulse_idx != 2'h3)
        else $error("too many pulses in call mode");

    AST_VEC_LEN: assert property (
        @(posedge clock) disable iff (srst)
        (st_reg.is_ack && st_reg.mode86 && st_reg.state != PICH_IDLE)
        |-> st_reg.pulse_idx <= 2'h1)
        else $error("too many pulses in vector mode");

    // ========================================
    // Coverage
    COV_ACK85: cover property (@(posedge clock)
        st_reg.is_ack && !st_reg.mode86 && st_reg.pulse_idx == 2'h2);
    COV_ACK86: cover property (@(posedge clock)
        st_reg.is_ack && st_reg.mode86 && st_reg.pulse_idx == 2'h1);
    COV_WRITE: cover property (@(posedge clock) $fell(wr_n));
    COV_READ: cover property (@(posedge clock) $fell(rd_n));
    COV_INT: cover property (@(posedge clock) $rose(irq));
endmodule

// ### test/pich_dev_model.sv
// Behavioural model of the interrupt controller device pins
module pich_dev_model (
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       ack_n,
    input  wire logic       a0,
    input  wire logic [7:0] host_dout,
    input  wire logic       host_oe,
    input  wire logic       mode86,
    input  wire logic [7:0] req,
    output logic      [7:0] bus,
    output logic            int_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // State
    logic [7:0] mask, insvc, pend, vec_hi, wbuf, rb, last;
    logic [2:0] base_lo, lvl;
    logic [1:0] cnt;
    logic       need_hi, rd_isr, wseen, wr_q, ack_q;

    function automatic logic [2:0] top(input logic [7:0] p);
        top = 3'h0;
        for (int i = 7; i >= 0; i--) if (p[i]) top = i[2:0];
    endfunction

    // One master, unbuffered, slave-program tied high
    assign pend = req & ~mask;
    assign int_out = |pend;

    always_ff @(posedge clock) begin
        wr_q <= wr_n;
        ack_q <= ack_n;
        last <= bus;
        if (srst) begin
            {mask, insvc, vec_hi, base_lo, lvl, cnt, last} <= '0;
            {need_hi, rd_isr, wseen} <= '0;
        end else begin
            if (!wr_n && !cs_n) begin
                wbuf <= bus;
                wseen <= 1'b1;
            end
            if (wr_n && !wr_q && wseen) begin
                wseen <= 1'b0;
                if (!a0 && wbuf[4]) begin
                    mask <= 8'h00;
                    base_lo <= wbuf[7:5];
                    need_hi <= 1'b1;
                    rd_isr <= 1'b0;
                end else if (!a0 && wbuf[3]) begin
                    if (wbuf[1]) rd_isr <= wbuf[0];
                end else if (a0 && need_hi) begin
                    vec_hi <= wbuf;
                    need_hi <= 1'b0;
                end else if (a0) mask <= wbuf;
            end
            if (!ack_n && ack_q && cnt == 2'h0) begin
                lvl <= top(pend);
                insvc[top(pend)] <= 1'b1;
            end
            if (ack_n && !ack_q) begin
                cnt <= (cnt == (mode86 ? 2'h1 : 2'h2)) ? 2'h0 : cnt + 2'h1;
            end
        end
    end

    always_comb begin
        rb = ~last;
        if (!cs_n && !rd_n) begin
            rb = a0 ? mask : (rd_isr ? insvc : pend);
        end else if (!ack_n && mode86 && cnt == 2'h1) begin
            rb = {vec_hi[7:3], lvl};
        end else if (!ack_n && !mode86 && cnt == 2'h0) begin
            rb = 8'hCD;
        end else if (!ack_n && !mode86 && cnt == 2'h1) begin
            rb = {base_lo, lvl, 2'b00};
        end else if (!ack_n && !mode86) begin
            rb = vec_hi;
        end
        bus = host_oe ? host_dout : rb;
    end
endmodule

// ### test/test_pich_host.sv
// Self-checking bench of the interrupt host port
`include "pich_defs.svh"
module test_pich_host
    import pich_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, srst, psel, penable, pwrite, pready, pslverr, irq;
    logic        cs_n, rd_n, wr_n, ack_n, psb, data_oe, dev_int, mode86;
    logic [7:0]  paddr, data_in, data_out, req;
    logic [31:0] pwdata, prdata, q;
    int          error_cnt, checked, n;

    pich_host i_pich_host (.clock(clock), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .irq_acknowledge_n(ack_n),
        .port_select_bit(psb), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .dev_int(dev_int));
    pich_dev_model i_pich_dev_model (.clock(clock), .srst(srst),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ack_n(ack_n), .a0(psb),
        .host_dout(data_out), .host_oe(data_oe), .mode86(mode86),
        .req(req), .bus(data_in), .int_out(dev_int));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // ========================================
    // Tasks
    task automatic final_report;
        $display("Checks %0d, errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        @(posedge clock);
        while (pready !== 1'b1 && k < 50) begin
            @(posedge clock);
            k++;
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            final_report();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic idle;
        int k;
        for (k = 0; k < 100; k++) begin
            apb(1'b0, `PICH_OFF_CTRL, 32'h0);
            if (q[0] === 1'b0) break;
        end
        if (k == 100) begin
            error_cnt++;
            final_report();
        end
    endtask
    task automatic pin(input logic [4:0] c, input logic [7:0] d);
        apb(1'b1, `PICH_OFF_WDATA, {24'h0, d});
        apb(1'b1, `PICH_OFF_CTRL, {27'h0, c});
        idle();
    endtask
    // ========================================
    // Sequence
    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {mode86, req, error_cnt, checked} = '0;
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        rd(`PICH_OFF_CTRL, 32'h0);
        chk({31'h0, cs_n & rd_n & wr_n & ack_n}, 32'h1);
        pin(5'h01, 8'h56);
        pin(5'h05, 8'h80);
        pin(5'h05, 8'hF0);
        pin(5'h07, 8'h00);
        rd(`PICH_OFF_RDATA, 32'hF0);
        apb(1'b1, `PICH_OFF_WDATA, 32'h0);
        apb(1'b1, `PICH_OFF_CTRL, 32'h5);
        apb(1'b1, `PICH_OFF_WDATA, 32'hAA);
        idle();
        pin(5'h07, 8'h00);
        rd(`PICH_OFF_RDATA, 32'h0);
        rd(`PICH_OFF_IRQ_STAT, 32'h1);
        apb(1'b1, `PICH_OFF_IRQ_STAT, 32'h3);
        rd(`PICH_OFF_IRQ_STAT, 32'h0);
        rd(8'h1C, 32'h0);
        apb(1'b1, `PICH_OFF_IRQ_MASK, 32'h3);
        req <= 8'h04;
        for (n = 0; n < 50 && irq !== 1'b1; n++) @(posedge clock);
        chk({31'h0, irq}, 32'h1);
        rd(`PICH_OFF_IRQ_STAT, 32'h2);
        apb(1'b0, `PICH_OFF_STAT, 32'h0);
        chk(q & 32'h5, 32'h4);
        chk({31'h0, pslverr}, 32'h0);
        apb(1'b1, `PICH_OFF_IRQ_MASK, 32'h0);
        rd(`PICH_OFF_IRQ_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        pin(5'h03, 8'h00);
        rd(`PICH_OFF_RDATA, 32'h04);
        pin(5'h09, 8'h00);
        rd(`PICH_OFF_VECTOR, 32'h8048CD);
        req <= 8'h60;
        mode86 <= 1'b1;
        pin(5'h19, 8'h00);
        apb(1'b0, `PICH_OFF_VECTOR, 32'h0);
        chk({24'h0, q[7:0]}, 32'h85);
        req <= 8'h00;
        pin(5'h01, 8'h0B);
        pin(5'h03, 8'h00);
        rd(`PICH_OFF_RDATA, 32'h24);
        final_report();
    end
endmodule
